/* shared/drive_run_defines.vh */
// constants for the drive run command logic
`ifndef DRIVE_RUN_DEFINES_VH
`define DRIVE_RUN_DEFINES_VH
// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS 100
`define DEBOUNCE_TIME_US 1000
// 1 ms of stable level at the 100 ns clock, sized to the counter
`define DEBOUNCE_CYCLES 14'h2710
`define DEBOUNCE_CNT_W 14
// ----------------------------------------
// setpoint source codes
// ----------------------------------------
`define SRC_DIGITAL_A 2'h1
`define SRC_DIGITAL_B 2'h2
// ----------------------------------------
// stop styles
// ----------------------------------------
`define STOP_RAMP 1'h0
`define STOP_COAST 1'h1
// ----------------------------------------
// drive states
// ----------------------------------------
`define ST_IDLE 3'h0
`define ST_RUN 3'h1
`define ST_RAMP 3'h2
`define ST_QUICK 3'h3
`define ST_LOCKED 3'h4
`define ST_FAULT 3'h5
// ----------------------------------------
// widths and reset values
// ----------------------------------------
`define SPD_W 12
`define SPD_RST 12'h000
`endif

/* logic/input_filter.v */
// synchroniser and debounce filter for one control input
`timescale 1ns/1ps
`default_nettype none
module input_filter #(
   parameter CNT_W = 14,
   parameter [CNT_W-1:0] STABLE = 14'h2710,
   parameter RST_VAL = 1'b0
) (
   // clock and reset
   input wire i_mclk,
   input wire i_nrst,
   // raw pin and clean level
   input wire i_raw,
   output reg o_clean
);
   reg sync1_r;
   reg sync2_r;
   reg [CNT_W-1:0] cnt_r;
   always @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         sync1_r <= RST_VAL;
         sync2_r <= RST_VAL;
         cnt_r <= {CNT_W{1'b0}};
         o_clean <= RST_VAL;
      end else begin
         sync1_r <= i_raw;
         sync2_r <= sync1_r;
         if (sync2_r == o_clean) begin
            cnt_r <= {CNT_W{1'b0}};
         end else if (cnt_r == STABLE - 1'b1) begin
            // level must hold for the whole window before it is taken
            o_clean <= sync2_r;
            cnt_r <= {CNT_W{1'b0}};
         end else begin
            cnt_r <= cnt_r + 1'b1;
         end
      end
   end
endmodule // input_filter
`default_nettype wire

/* logic/drive_run_command_logic.v */
// run, stop, fault, direction and setpoint command logic of a motor drive
//
// Overview of operation
// - the decrement input lowers the digital setpoint only when the source parameter is 1 or 2.
// - a start needs drive_permit plus a start, run_forward, run_backward or pulse command.
// - dropping drive_permit stops driving at once and lets the motor coast.
// - a low outside_fault_input switches the drive off and raises the external fault flag.
// - run_forward high accelerates forward on the selected ramp.
// - run_backward high accelerates in reverse on the selected ramp.
// - removing the active run input stops the motor as stop_style_param selects.
// - after that stop the drive is locked and does not restart by itself.
// - run_forward and run_backward are exclusive-or'd; both high ramps down on the quick ramp.
// - direction_flip high reverses the direction, low leaves it.
// - in pulse control an absent pulse halt blocks starting and stops a running motor as stop_style_param selects.
// - in pulse control a single forward or backward pulse latches the run command.
// - the analog source select picks analog_input_one when low, analog_input_two when high.
// - the analog/preset select picks the input chosen by the analog source select when low, a chosen preset when high.
// - heading_select with start: low means forward, high means reverse.
`timescale 1ns/1ps
`default_nettype none
`include "drive_run_defines.vh"
module drive_run_command_logic #(
   parameter SPD_W = `SPD_W,
   parameter CNT_W = `DEBOUNCE_CNT_W,
   parameter [CNT_W-1:0] DEBOUNCE = `DEBOUNCE_CYCLES
) (
   // clock and reset
   input wire i_mclk,
   input wire i_nrst,
   // terminal inputs
   input wire i_drive_permit,
   input wire i_outside_fault_input,
   input wire i_run_forward,
   input wire i_run_backward,
   input wire i_start,
   input wire i_heading_select,
   input wire i_direction_flip,
   input wire i_pulse_forward_input,
   input wire i_pulse_backward_input,
   input wire i_pulse_halt_input,
   input wire i_speed_up,
   input wire i_speed_down,
   input wire i_analog_source_sel,
   input wire i_preset_sel,
   input wire i_preset_bit0,
   input wire i_preset_bit1,
   // configuration
   input wire [1:0] i_control_mode,
   input wire [1:0] i_setpoint_source,
   input wire i_stop_style_param,
   input wire i_unlock,
   input wire i_ramp_done,
   // setpoint values
   input wire [SPD_W-1:0] i_analog_input_one,
   input wire [SPD_W-1:0] i_analog_input_two,
   input wire [SPD_W-1:0] i_preset_frequency0,
   input wire [SPD_W-1:0] i_preset_frequency1,
   input wire [SPD_W-1:0] i_preset_frequency2,
   input wire [SPD_W-1:0] i_preset_frequency3,
   // to ramp and speed control
   output reg o_run,
   output reg o_reverse,
   output reg o_coast,
   output reg o_ramp_stop,
   output reg o_quick_stop,
   output reg o_locked,
   output reg o_ext_fault,
   output reg [SPD_W-1:0] o_setpoint,
   output reg [SPD_W-1:0] o_digital_setpoint
);
   // ----------------------------------------
   // input conditioning
   // ----------------------------------------
   localparam NIN = 16;
   localparam MODE_LEVEL = 2'h0;
   localparam MODE_PULSE = 2'h1;
   localparam MODE_START = 2'h2;
   wire [NIN-1:0] raw = {i_preset_bit1, i_preset_bit0, i_preset_sel, i_analog_source_sel,
      i_speed_down, i_speed_up, i_pulse_halt_input, i_pulse_backward_input,
      i_pulse_forward_input, i_direction_flip, i_heading_select, i_start,
      i_run_backward, i_run_forward, i_outside_fault_input, i_drive_permit};
   // fault and halt rest high so reset does not trip them
   localparam [NIN-1:0] RST_MASK = 16'h0202;
   wire [NIN-1:0] cln;
   genvar g;
   generate
      for (g = 0; g < NIN; g = g + 1) begin : flt
         input_filter #(.CNT_W(CNT_W), .STABLE(DEBOUNCE), .RST_VAL(RST_MASK[g])) u_flt (
            .i_mclk(i_mclk),
            .i_nrst(i_nrst),
            .i_raw(raw[g]),
            .o_clean(cln[g])
         );
      end
   endgenerate
   wire permit = cln[0];
   wire fault_ok = cln[1];
   wire run_forward = cln[2];
   wire bwd = cln[3];
   wire start = cln[4];
   wire heading = cln[5];
   wire flip = cln[6];
   wire p_fwd = cln[7];
   wire p_bwd = cln[8];
   wire p_halt = cln[9];
   wire up = cln[10];
   wire down = cln[11];
   wire ai_sel = cln[12];
   wire pre_sel = cln[13];
   wire [1:0] pre_idx = cln[15:14];
   // ----------------------------------------
   // run request decode
   // ----------------------------------------
   reg [2:0] state_r;
   reg [2:0] state_nxt;
   reg latch_r;
   reg latch_dir_r;
   reg p_fwd_d_r;
   reg p_bwd_d_r;
   reg want_run;
   reg want_rev;
   reg both_hi;
   always @* begin
      want_run = 1'b0;
      want_rev = 1'b0;
      both_hi = 1'b0;
      case (i_control_mode)
         MODE_LEVEL: begin
            want_run = run_forward ^ bwd;
            want_rev = bwd & ~run_forward;
            both_hi = run_forward & bwd;
         end
         MODE_PULSE: begin
            want_run = latch_r & p_halt;
            want_rev = latch_dir_r;
         end
         MODE_START: begin
            want_run = start;
            want_rev = heading;
         end
         default: begin
            want_run = 1'b0;
         end
      endcase
   end
   wire p_fwd_edge = p_fwd & ~p_fwd_d_r;
   wire p_bwd_edge = p_bwd & ~p_bwd_d_r;
   // ----------------------------------------
   // drive state machine
   // ----------------------------------------
   always @* begin
      state_nxt = state_r;
      case (state_r)
         `ST_IDLE: begin
            if (permit && want_run) state_nxt = `ST_RUN;
         end
         `ST_RUN: begin
            if (both_hi) state_nxt = `ST_QUICK;
            else if (!want_run) state_nxt = `ST_RAMP;
         end
         `ST_RAMP: begin
            if (i_stop_style_param == `STOP_COAST || i_ramp_done) state_nxt = `ST_LOCKED;
         end
         `ST_QUICK: begin
            if (i_ramp_done) state_nxt = `ST_LOCKED;
         end
         `ST_LOCKED: begin
            // only a deliberate unlock with no run pending re-arms the drive
            if (i_unlock && !want_run && !both_hi) state_nxt = `ST_IDLE;
         end
         `ST_FAULT: begin
            if (fault_ok && i_unlock) state_nxt = `ST_IDLE;
         end
         default: state_nxt = `ST_IDLE;
      endcase
      if (!permit && state_r != `ST_FAULT && state_r != `ST_IDLE) state_nxt = `ST_LOCKED;
      if (!fault_ok) state_nxt = `ST_FAULT;
   end
   always @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         state_r <= `ST_IDLE;
         latch_r <= 1'b0;
         latch_dir_r <= 1'b0;
         p_fwd_d_r <= 1'b0;
         p_bwd_d_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         p_fwd_d_r <= p_fwd;
         p_bwd_d_r <= p_bwd;
         if (!p_halt || !permit || !fault_ok) begin
            latch_r <= 1'b0;
         end else if (p_fwd_edge ^ p_bwd_edge) begin
            latch_r <= 1'b1;
            latch_dir_r <= p_bwd_edge;
         end
      end
   end
   // ----------------------------------------
   // digital setpoint and source select
   // ----------------------------------------
   wire dig_src = (i_setpoint_source == `SRC_DIGITAL_A) || (i_setpoint_source == `SRC_DIGITAL_B);
   reg up_d_r;
   reg down_d_r;
   reg [SPD_W-1:0] pre_val;
   reg [SPD_W-1:0] sp_nxt;
   always @* begin
      case (pre_idx)
         2'h0: pre_val = i_preset_frequency0;
         2'h1: pre_val = i_preset_frequency1;
         2'h2: pre_val = i_preset_frequency2;
         default: pre_val = i_preset_frequency3;
      endcase
      if (dig_src) sp_nxt = o_digital_setpoint;
      else if (pre_sel) sp_nxt = pre_val;
      else if (ai_sel) sp_nxt = i_analog_input_two;
      else sp_nxt = i_analog_input_one;
   end
   // ----------------------------------------
   // outputs
   // ----------------------------------------
   wire active = (state_nxt == `ST_RUN);
   always @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_run <= 1'b0;
         o_reverse <= 1'b0;
         o_coast <= 1'b1;
         o_ramp_stop <= 1'b0;
         o_quick_stop <= 1'b0;
         o_locked <= 1'b0;
         o_ext_fault <= 1'b0;
         o_setpoint <= `SPD_RST;
         o_digital_setpoint <= `SPD_RST;
         up_d_r <= 1'b0;
         down_d_r <= 1'b0;
      end else begin
         o_run <= active;
         if (active) o_reverse <= want_rev ^ flip;
         o_coast <= !active && (state_nxt != `ST_QUICK) &&
            !(state_nxt == `ST_RAMP && i_stop_style_param == `STOP_RAMP);
         o_ramp_stop <= (state_nxt == `ST_RAMP) && (i_stop_style_param == `STOP_RAMP);
         o_quick_stop <= (state_nxt == `ST_QUICK);
         o_locked <= (state_nxt == `ST_LOCKED);
         o_ext_fault <= (state_nxt == `ST_FAULT);
         o_setpoint <= sp_nxt;
         up_d_r <= up;
         down_d_r <= down;
         // one step per press; holding a button does not run away
         if (dig_src && down && !down_d_r && o_digital_setpoint != {SPD_W{1'b0}}) begin
            o_digital_setpoint <= o_digital_setpoint - 1'b1;
         end else if (dig_src && up && !up_d_r && o_digital_setpoint != {SPD_W{1'b1}}) begin
            o_digital_setpoint <= o_digital_setpoint + 1'b1;
         end
      end
   end
endmodule // drive_run_command_logic
`default_nettype wire

/* testbench/drive_run_assertions.sv */
// assertion checker for the drive run command logic
`timescale 1ns/1ps
`default_nettype none
module drive_run_assertions #(parameter SPD_W = 12) (
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_nrst,
   // watched inputs
   input wire logic i_drive_permit,
   input wire logic i_outside_fault_input,
   input wire logic i_run_forward,
   input wire logic i_run_backward,
   input wire logic i_direction_flip,
   input wire logic [1:0] i_control_mode,
   input wire logic [1:0] i_setpoint_source,
   input wire logic i_stop_style_param,
   input wire logic i_unlock,
   // watched outputs
   input wire logic o_run,
   input wire logic o_reverse,
   input wire logic o_coast,
   input wire logic o_ramp_stop,
   input wire logic o_quick_stop,
   input wire logic o_locked,
   input wire logic o_ext_fault,
   input wire logic [SPD_W-1:0] o_digital_setpoint
);
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_nrst);
   a_fault_coast: assert property (o_ext_fault |-> o_coast && !o_run) else $error("fault not coasting");
   // filter plus output register: about seven cycles from pin to flag
   a_fault_pin: assert property (!i_outside_fault_input [*8] |-> ##[0:4] o_ext_fault) else $error("no fault");
   a_coast_idle: assert property (o_coast |-> !o_run) else $error("coast while running");
   a_permit_run: assert property ($rose(o_run) |-> i_drive_permit) else $error("start without permit");
   a_locked_hold: assert property (o_locked && !i_unlock |=> !o_run) else $error("restart from lock");
   a_quick_both: assert property ($rose(o_quick_stop) |-> i_run_forward && i_run_backward && !o_run)
      else $error("bad quick stop");
   a_ramp_style: assert property ($rose(o_ramp_stop) |-> !i_stop_style_param && !o_run)
      else $error("bad ramp stop");
   a_dir_start: assert property ($rose(o_run) && i_control_mode == 2'h0 |->
      o_reverse == (i_run_backward ^ i_direction_flip)) else $error("bad direction");
   a_down_src: assert property (o_digital_setpoint < $past(o_digital_setpoint) |->
      i_setpoint_source == 2'h1 || i_setpoint_source == 2'h2) else $error("bad decrement");
endmodule // drive_run_assertions
bind drive_run_command_logic drive_run_assertions #(.SPD_W(SPD_W)) chk_inst (.i_mclk, .i_nrst, .i_drive_permit,
   .i_outside_fault_input, .i_run_forward, .i_run_backward, .i_direction_flip, .i_control_mode, .i_setpoint_source,
   .i_stop_style_param, .i_unlock, .o_run, .o_reverse, .o_coast, .o_ramp_stop, .o_quick_stop, .o_locked,
   .o_ext_fault, .o_digital_setpoint);
`default_nettype wire

/* testbench/terminal_model.sv */
// switch model driving permit, fault, run and halt terminals
`timescale 1ns/1ps
`default_nettype none
module terminal_model (
   // clock
   input wire logic i_mclk,
   // wanted positions: permit, fault_ok, fwd, bwd, halt
   input wire logic [4:0] i_want,
   // terminal levels
   output logic [4:0] o_pins
);
   logic [4:0] req_r = 5'h09;
   logic [4:0] pins_r = 5'h09; // fault and halt contacts closed when idle
   // taken at rise, shown at fall, so the bench's own fall writes never race
   always @(posedge i_mclk) req_r <= i_want;
   // separate fwd/bwd contacts, no level direction wire; run levels pass through even without permit
   always @(negedge i_mclk) pins_r <= req_r;
   assign o_pins = pins_r;
endmodule // terminal_model
`default_nettype wire

/* testbench/tb_drive_run_command_logic.sv */
// self-checking testbench for the drive run command logic
`timescale 1ns/1ps
`default_nettype none
module tb_drive_run_command_logic;
   logic i_mclk = 1'h0, i_nrst = 1'h0, i_direction_flip = 1'h0, i_speed_up = 1'h0, i_speed_down = 1'h0;
   logic i_analog_source_sel = 1'h0, i_preset_sel = 1'h0, i_preset_bit0 = 1'h0, i_preset_bit1 = 1'h0;
   logic i_stop_style_param = 1'h0, i_unlock = 1'h0, i_ramp_done = 1'h0;
   logic i_start = 1'h0, i_heading_select = 1'h0, i_pulse_forward_input = 1'h0, i_pulse_backward_input = 1'h0;
   logic [1:0] i_setpoint_source = 2'h0, i_control_mode = 2'h0;
   logic [4:0] want = 5'h09;
   logic [11:0] d, ai1 = 12'h123, ai2 = 12'h456;
   logic [11:0] pf [4] = '{12'h111, 12'h222, 12'h333, 12'h444};
   wire logic [4:0] pins;
   wire logic i_drive_permit, i_outside_fault_input, i_run_forward, i_run_backward, i_pulse_halt_input;
   wire logic o_run, o_reverse, o_coast, o_ramp_stop, o_quick_stop, o_locked, o_ext_fault;
   wire logic [11:0] o_setpoint, o_digital_setpoint;
   int fail_count = 0, n_checks = 0;
   assign {i_drive_permit, i_outside_fault_input, i_run_forward, i_run_backward, i_pulse_halt_input} = pins;
   always #50 i_mclk = ~i_mclk;
   terminal_model terminal_model_inst (.i_mclk, .i_want(want), .o_pins(pins));
   // short debounce keeps each level change near seven cycles
   drive_run_command_logic #(.DEBOUNCE(14'h0004)) drive_run_command_logic_inst (.i_mclk, .i_nrst, .i_drive_permit,
      .i_outside_fault_input, .i_run_forward, .i_run_backward, .i_start, .i_heading_select,
      .i_direction_flip, .i_pulse_forward_input, .i_pulse_backward_input, .i_pulse_halt_input,
      .i_speed_up, .i_speed_down, .i_analog_source_sel, .i_preset_sel, .i_preset_bit0, .i_preset_bit1,
      .i_control_mode, .i_setpoint_source, .i_stop_style_param, .i_unlock, .i_ramp_done,
      .i_analog_input_one(ai1), .i_analog_input_two(ai2), .i_preset_frequency0(pf[0]), .i_preset_frequency1(pf[1]),
      .i_preset_frequency2(pf[2]), .i_preset_frequency3(pf[3]), .o_run, .o_reverse, .o_coast, .o_ramp_stop,
      .o_quick_stop, .o_locked, .o_ext_fault, .o_setpoint, .o_digital_setpoint);
   task step(input int n);
      repeat (n) @(negedge i_mclk);
   endtask
   task chk(input logic [11:0] got, input logic [11:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task set(input logic [4:0] w);
      want = w;
      step(12);
   endtask
   task unlock_all;
      i_ramp_done = 1'h1;
      set(5'h19);
      i_unlock = 1'h1;
      step(2);
      i_unlock = 1'h0;
      i_ramp_done = 1'h0;
      step(2);
   endtask
   task tap(input logic dn);
      i_speed_down = dn;
      i_speed_up = ~dn;
      step(12);
      i_speed_down = 1'h0;
      i_speed_up = 1'h0;
      step(12);
   endtask
   task pulse(input logic bk);
      if (bk) i_pulse_backward_input = 1'h1;
      else i_pulse_forward_input = 1'h1;
      step(12);
      i_pulse_forward_input = 1'h0;
      i_pulse_backward_input = 1'h0;
      step(12);
   endtask
   task report_and_stop;
      $display("checks %0d, mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial begin
      step(16);
      i_nrst = 1'h1;
      step(12);
      chk({o_run, o_locked, o_ext_fault, o_coast}, 4'h1);
      set(5'h0D);
      chk(o_run, 1'h0);
      set(5'h19);
      want = 5'h1D;
      step(2);
      set(5'h19);
      chk(o_run, 1'h0);
      $display("test start_refusal done");
      set(5'h1D);
      chk({o_run, o_reverse, o_coast}, 3'h4);
      set(5'h19);
      chk({o_run, o_ramp_stop}, 2'h1);
      i_ramp_done = 1'h1;
      step(4);
      chk({o_locked, o_coast}, 2'h3);
      i_ramp_done = 1'h0;
      set(5'h1D);
      chk(o_run, 1'h0);
      $display("test run_stop_lock done");
      for (int i = 0; i < 2; i++) begin
         i_direction_flip = i[0];
         unlock_all();
         set(i ? 5'h1D : 5'h1B);
         chk({o_run, o_reverse}, 2'h3);
      end
      set(5'h1F);
      chk({o_run, o_quick_stop}, 2'h1);
      i_direction_flip = 1'h0;
      unlock_all();
      set(5'h1D);
      set(5'h0D);
      chk({o_run, o_ramp_stop, o_coast, o_locked}, 4'h3);
      unlock_all();
      set(5'h1D);
      set(5'h15);
      chk({o_run, o_ext_fault, o_coast}, 3'h3);
      unlock_all();
      $display("test stops_fault done");
      for (int k = 0; k < 6; k++) begin
         i_analog_source_sel = (k == 1);
         i_preset_sel = (k > 1);
         {i_preset_bit1, i_preset_bit0} = 2'(k - 2);
         step(12);
         chk(o_setpoint, k == 0 ? ai1 : k == 1 ? ai2 : pf[k - 2]);
      end
      i_setpoint_source = 2'h1;
      tap(1'h0);
      tap(1'h0);
      d = o_digital_setpoint;
      chk(d, 12'h002);
      chk(o_setpoint, 12'h002);
      i_setpoint_source = 2'h3;
      tap(1'h1);
      chk(o_digital_setpoint, d);
      i_setpoint_source = 2'h2;
      tap(1'h1);
      chk(o_digital_setpoint, 12'h001);
      $display("test setpoint done");
      i_control_mode = 2'h1;
      pulse(1'h0);
      chk({o_run, o_reverse}, 2'h2);
      set(5'h18);
      chk({o_run, o_ramp_stop}, 2'h1);
      unlock_all();
      set(5'h18);
      pulse(1'h1);
      set(5'h19);
      chk(o_run, 1'h0);
      pulse(1'h1);
      chk({o_run, o_reverse}, 2'h3);
      set(5'h18);
      unlock_all();
      $display("test pulse_control done");
      i_control_mode = 2'h2;
      i_stop_style_param = 1'h1;
      i_heading_select = 1'h1;
      i_start = 1'h1;
      step(12);
      chk({o_run, o_reverse}, 2'h3);
      i_start = 1'h0;
      step(12);
      chk({o_run, o_ramp_stop, o_coast, o_locked}, 4'h3);
      $display("test start_heading done");
      report_and_stop();
   end
   // tests need about 614 cycles; over eleven times that means a hang
   initial begin
      repeat (7000) @(posedge i_mclk);
      fail_count++;
      report_and_stop();
   end
endmodule // tb_drive_run_command_logic
`default_nettype wire
